// [hw/ordet_chan.sv]
/*
 * one channel of the over-range detector: magnitude fold, threshold
 * compare and the hold counter that stretches the flag.
 * assumes samples arrive on clk, already in the sample-clock domain.
 */
`timescale 1ns/1ps

module ordet_chan
  import ordet_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ordet_chan_if.det ch
);

  logic [ORDET_SAMPLE_W:0] neg_ext;
  logic [ORDET_MAG_W-1:0] mag;
  logic hit;
  logic [ORDET_CNT_W-1:0] hold_len;
  logic [ORDET_CNT_W-1:0] cnt_ff;
  logic [ORDET_CNT_W-1:0] nxt_cnt;
  logic flag_ff;
  logic hit_ff;
  logic [ORDET_MAG_W-1:0] mag_ff;

  // ==========================================================
  // magnitude fold
  // negation in one extra bit so that -256 saturates instead of wrapping
  assign neg_ext = '0 - {ch.sample[ORDET_SAMPLE_W-1], ch.sample};
  always_comb begin
    if (!ch.sample[ORDET_SAMPLE_W-1]) begin
      mag = ch.sample[ORDET_MAG_W-1:0];
    end else if (neg_ext[ORDET_SAMPLE_W-1]) begin
      mag = ORDET_MAG_MAX;
    end else begin
      mag = neg_ext[ORDET_MAG_W-1:0];
    end
  end

  // compare every valid sample, no decimation for lowest latency
  assign hit = ch.enable && ch.sample_valid &&
               (mag >= ch.threshold);
  assign hold_len = ORDET_HOLD_BASE << ch.hold_sel;

  // ==========================================================
  // hold counter
  always_comb begin
    if (!ch.enable) begin
      nxt_cnt = '0;
    end else if (hit) begin
      nxt_cnt = hold_len;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
      flag_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      flag_ff <= (nxt_cnt != '0);
    end
  end

  // event pulse and last magnitude for the register side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_ff <= 1'b0;
      mag_ff <= '0;
    end else begin
      hit_ff <= hit;
      if (ch.sample_valid) begin
        mag_ff <= mag;
      end
    end
  end

  assign ch.hit_pulse = hit_ff;
  assign ch.flag = flag_ff;
  assign ch.magnitude = mag_ff;

endmodule

// [hw/ordet_chan_if.sv]
/*
 * carrier between the detector top and one per-channel detector.
 * assumes the top drives configuration and samples on its own clock.
 */
`timescale 1ns/1ps

interface ordet_chan_if;
  import ordet_pkg::*;

  // ==========================================================
  // configuration and sample towards the channel
  logic enable;
  logic [ORDET_SEL_W-1:0] hold_sel;
  logic [ORDET_MAG_W-1:0] threshold;
  logic [ORDET_SAMPLE_W-1:0] sample;
  logic sample_valid;

  // ==========================================================
  // results from the channel
  logic hit_pulse;
  logic flag;
  logic [ORDET_MAG_W-1:0] magnitude;

  modport det (
    input enable,
    input hold_sel,
    input threshold,
    input sample,
    input sample_valid,
    output hit_pulse,
    output flag,
    output magnitude
  );

  modport ctl (
    output enable,
    output hold_sel,
    output threshold,
    output sample,
    output sample_valid,
    input hit_pulse,
    input flag,
    input magnitude
  );
endinterface

// [hw/ordet_pkg.sv]
/*
 * constants shared by the over-range detector: register map, field layout,
 * reset values and datapath widths.
 * assumes a 32-bit apb slave and one sample per clock per channel.
 */
package ordet_pkg;

  // ==========================================================
  // datapath widths
  localparam int ORDET_MAX_CHAN = 4;
  localparam int ORDET_SAMPLE_W = 9;
  localparam int ORDET_MAG_W = 8;
  localparam int ORDET_SEL_W = 3;
  localparam int ORDET_CNT_W = 11;
  localparam logic [ORDET_CNT_W-1:0] ORDET_HOLD_BASE = 11'h008;
  localparam logic [ORDET_MAG_W-1:0] ORDET_MAG_MAX = 8'hFF;

  // ==========================================================
  // apb register map (byte addresses)
  localparam int ORDET_ADDR_W = 8;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_CTRL_OFS = 8'h00;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_THRESH_OFS = 8'h04;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_FLAGS_OFS = 8'h08;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_IRQ_STAT_OFS = 8'h0C;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_IRQ_MASK_OFS = 8'h10;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_PEAK_BASE_OFS = 8'h20;
  localparam logic [ORDET_ADDR_W-1:0] ORDET_PEAK_STRIDE = 8'h04;

  // ==========================================================
  // control register fields
  localparam int ORDET_CTRL_EN_BIT = 0;
  localparam int ORDET_CTRL_SEL_LSB = 1;
  localparam int ORDET_CTRL_REFC_BIT = 4;
  localparam int ORDET_CTRL_REFD_BIT = 5;

  // ==========================================================
  // reset values
  localparam logic [ORDET_MAG_W-1:0] ORDET_THRESH_RST = 8'hE4;
  localparam logic [ORDET_SEL_W-1:0] ORDET_SEL_RST = 3'h0;

endpackage

// [hw/ordet_top.sv]
/*
 * over-range detector top: apb register file, one detector per channel,
 * sticky event status with mask and interrupt, and the flag pins.
 * assumes clk is the sample clock, samples arrive synchronous to it,
 * and an outside mux builds the divided reference clock on pins c/d.
 * assumes software sets the threshold
 * before it turns detection on.
 * pins past NUM_CHAN are tied low.
 */
`timescale 1ns/1ps

// Contract
// - check every 9-bit sample with low latency
// - compare upper 8 magnitude bits with threshold
// - fold sample: +255/-256 give 255, 0 gives 0
// - detection only while enable is set
// - flag high when magnitude reaches threshold
// - one flag pin per channel, a to d
// - hold flag 8 times 2^n cycles after event
// - reference clock function overrides pins c, d
// - samples are signed two's complement
module ordet_top
  import ordet_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic clk,
  input wire logic rst,
  // apb slave
  // byte addresses, one word each
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ORDET_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // samples, one per channel per clock
  // a sample counts only while valid
  input wire logic [NUM_CHAN-1:0][ORDET_SAMPLE_W-1:0] sample_data,
  input wire logic [NUM_CHAN-1:0] sample_valid,
  // flag pins
  output logic flag_pin_chan_a,
  output logic flag_pin_chan_b,
  output logic flag_pin_chan_c,
  output logic flag_pin_chan_d,
  // pin function select towards the reference clock mux
  // d takes effect only with c
  output logic chan_c_pin_refclk_function,
  output logic chan_d_pin_refclk_function,
  output logic irq
);

  // ==========================================================
  // declarations
  // one flop group per register, so a
  // write touches only its own concern.
  // channel vectors follow NUM_CHAN,
  // pin vectors always span four pins.
  // settings first, then results
  logic enable_ff;
  logic [ORDET_SEL_W-1:0] hold_sel_ff;
  logic refc_ff;
  logic refd_ff;
  logic [ORDET_MAG_W-1:0] thresh_ff;
  logic [NUM_CHAN-1:0] irq_stat_ff;
  logic [NUM_CHAN-1:0] irq_mask_ff;
  logic [NUM_CHAN-1:0][ORDET_MAG_W-1:0] peak_ff;
  logic [31:0] prdata_ff;
  logic [ORDET_MAX_CHAN-1:0] pin_ff;

  // results gathered from the channels
  logic [NUM_CHAN-1:0] chan_hit;
  logic [NUM_CHAN-1:0] chan_flag;
  logic [NUM_CHAN-1:0][ORDET_MAG_W-1:0] chan_mag;
  logic [ORDET_MAX_CHAN-1:0] flag_all;
  logic [ORDET_MAX_CHAN-1:0] pin_block;
  logic refc_eff;
  logic refd_eff;

  // bus decode terms
  logic setup_ph;
  logic wr_acc;
  logic wr_ctrl;
  logic wr_thresh;
  logic wr_stat;
  logic wr_mask;
  logic peak_sel;
  logic [ORDET_ADDR_W-1:0] peak_ofs;
  logic [ORDET_ADDR_W-1:0] peak_idx;
  logic peak_hit;
  logic addr_ok;
  logic [31:0] nxt_prdata;

  // ==========================================================
  // apb decode
  // zero wait states: read data is caught in the setup cycle
  // the read mux is sampled at the setup
  // edge, so prdata is settled before the
  // access phase opens.
  // trade-off: one flop word buys a bus
  // path that does not grow with channels.
  // writes land only at the access edge,
  // where the master sees pready high.
  // a read never changes any state,
  // so a repeated read is harmless.
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign wr_ctrl = wr_acc && (paddr == ORDET_CTRL_OFS);
  assign wr_thresh = wr_acc && (paddr == ORDET_THRESH_OFS);
  assign wr_stat = wr_acc && (paddr == ORDET_IRQ_STAT_OFS);
  assign wr_mask = wr_acc && (paddr == ORDET_IRQ_MASK_OFS);

  // peak window: one word per channel from the peak base
  // alignment and range are both checked:
  // an address past the last channel is
  // refused, never aliased onto channel 0.
  assign peak_ofs = paddr - ORDET_PEAK_BASE_OFS;
  assign peak_idx = peak_ofs / ORDET_PEAK_STRIDE;
  assign peak_sel = (paddr >= ORDET_PEAK_BASE_OFS) &&
                    (peak_ofs[1:0] == 2'h0) &&
                    (peak_idx < ORDET_ADDR_W'(NUM_CHAN));
  assign peak_hit = wr_acc && peak_sel;

  assign addr_ok = (paddr == ORDET_CTRL_OFS) ||
                   (paddr == ORDET_THRESH_OFS) ||
                   (paddr == ORDET_FLAGS_OFS) ||
                   (paddr == ORDET_IRQ_STAT_OFS) ||
                   (paddr == ORDET_IRQ_MASK_OFS) ||
                   peak_sel;

  assign pready = 1'b1;
  // unmapped address answers with an error, writes there are dropped
  // pready never falls: each access
  // phase ends at its first edge.
  // pslverr stands only with psel and
  // penable high, never in setup.
  assign pslverr = psel && penable && !addr_ok;

  // ==========================================================
  // control register
  // enable, hold length and pin functions
  // share one word, written together.
  // a new hold length does not cut a
  // running count; it applies from the
  // next event onward.
  // clearing enable drops every flag at
  // the next edge.
  // pin functions are plain selects here.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_ff <= 1'b0;
      hold_sel_ff <= ORDET_SEL_RST;
      refc_ff <= 1'b0;
      refd_ff <= 1'b0;
    end else if (wr_ctrl) begin
      enable_ff <= pwdata[ORDET_CTRL_EN_BIT];
      hold_sel_ff <= pwdata[ORDET_CTRL_SEL_LSB +: ORDET_SEL_W];
      refc_ff <= pwdata[ORDET_CTRL_REFC_BIT];
      refd_ff <= pwdata[ORDET_CTRL_REFD_BIT];
    end
  end

  // threshold register; reset default sits near full scale
  // low eight bits kept; compared with the
  // folded magnitude, so one value guards
  // both signs of the input.
  // limitation: zero flags every sample.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thresh_ff <= ORDET_THRESH_RST;
    end else if (wr_thresh) begin
      thresh_ff <= pwdata[ORDET_MAG_W-1:0];
    end
  end

  // ==========================================================
  // event status, write one to clear; a new event beats the clear
  // fed by the one-cycle hit pulse, not
  // the stretched flag: one event, one
  // count, however long the flag stands.
  // an event in the cycle of a clear is
  // kept; losing it would hide an
  // over-range from polling software.
  // bits past NUM_CHAN do not exist.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff &
                      ~(wr_stat ? pwdata[NUM_CHAN-1:0] : '0)) |
                     chan_hit;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_ff <= '0;
    end else if (wr_mask) begin
      irq_mask_ff <= pwdata[NUM_CHAN-1:0];
    end
  end

  // level interrupt while any unmasked event bit stands
  // no edge is made here: the line stays
  // up until software clears or masks it.
  // the mask only gates the line, never
  // the status, so polling still works.
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ==========================================================
  // per-channel detectors and peak magnitude capture
  // one carrier per channel; the top
  // fans the shared settings out and
  // gathers the results back.
  // all channels see the same settings,
  // so they cannot drift apart.
  // the carrier keeps the bundle whole.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      ordet_chan_if u_if ();

      assign u_if.enable = enable_ff;
      assign u_if.hold_sel = hold_sel_ff;
      assign u_if.threshold = thresh_ff;
      assign u_if.sample = sample_data[gi];
      assign u_if.sample_valid = sample_valid[gi];
      assign chan_hit[gi] = u_if.hit_pulse;
      assign chan_flag[gi] = u_if.flag;
      assign chan_mag[gi] = u_if.magnitude;

      ordet_chan u_chan (
        .clk (clk),
        .rst (rst),
        .ch (u_if)
      );

      // largest magnitude seen; any write to its word clears it
      // the peak uses the registered
      // magnitude, one clock behind the
      // sample; harmless for a value read
      // long after the event.
      // the last magnitude reloads on the
      // next edge, so a read after a clear
      // shows the latest sample, not zero.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          peak_ff[gi] <= '0;
        end else if (peak_hit &&
                     (peak_idx == ORDET_ADDR_W'(gi))) begin
          peak_ff[gi] <= '0;
        end else if (chan_mag[gi] > peak_ff[gi]) begin
          peak_ff[gi] <= chan_mag[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // read mux
  // unused bits read as zero.
  // a peak word past the channel range
  // never reaches the index below, so
  // the index stays inside the array.
  // every path starts from zero.
  always_comb begin
    nxt_prdata = '0;
    if (paddr == ORDET_CTRL_OFS) begin
      nxt_prdata[ORDET_CTRL_EN_BIT] = enable_ff;
      nxt_prdata[ORDET_CTRL_SEL_LSB +: ORDET_SEL_W] = hold_sel_ff;
      nxt_prdata[ORDET_CTRL_REFC_BIT] = refc_ff;
      nxt_prdata[ORDET_CTRL_REFD_BIT] = refd_ff;
    end else if (paddr == ORDET_THRESH_OFS) begin
      nxt_prdata[ORDET_MAG_W-1:0] = thresh_ff;
    end else if (paddr == ORDET_FLAGS_OFS) begin
      nxt_prdata[NUM_CHAN-1:0] = chan_flag;
    end else if (paddr == ORDET_IRQ_STAT_OFS) begin
      nxt_prdata[NUM_CHAN-1:0] = irq_stat_ff;
    end else if (paddr == ORDET_IRQ_MASK_OFS) begin
      nxt_prdata[NUM_CHAN-1:0] = irq_mask_ff;
    end else if (peak_sel) begin
      nxt_prdata[ORDET_MAG_W-1:0] = peak_ff[peak_idx[1:0]];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;

  // ==========================================================
  // flag pins
  // the d clock only exists while the c clock is on
  // the clock itself is built outside;
  // here only the pin function is chosen
  // and the flag is kept off the pin.
  // the channel flag counts on beneath,
  // so a running flag reappears when the
  // clock function is switched off.
  // flags word still shows c and d.
  assign refc_eff = refc_ff;
  assign refd_eff = refd_ff && refc_ff;
  assign chan_c_pin_refclk_function = refc_eff;
  assign chan_d_pin_refclk_function = refd_eff;

  // missing channels read as never flagged
  // a reduced build keeps all four pin
  // ports, so the pin map stays the same
  // across one, two and four channels.
  assign flag_all = ORDET_MAX_CHAN'(chan_flag);
  assign pin_block = {refd_eff, refc_eff, 2'b00};

  // pins are registered, one clock behind the channel flag
  // the flop keeps decode glitches off
  // the pins; same length as the flag,
  // one clock later.
  // trade-off: one clock of latency for
  // a clean pin.
  // reset clears the pins at once.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= flag_all & ~pin_block;
    end
  end

  assign flag_pin_chan_a = pin_ff[0];
  assign flag_pin_chan_b = pin_ff[1];
  assign flag_pin_chan_c = pin_ff[2];
  assign flag_pin_chan_d = pin_ff[3];

endmodule

// [sim/ordet_gain_model.sv]
/* downstream gain control model fed by the four flag pins.
   assumes flags are synchronous to clk. */
`timescale 1ns/1ps

module ordet_gain_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] flags,
  output logic gain_low_ff
);
  // ==========================================================
  // gain down while any flag is up; no smoothing, registered, so it reacts one clock later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) gain_low_ff <= 1'b0;
    else gain_low_ff <= |flags;
  end
endmodule

// [sim/ordet_monitor.sv]
/* checker for the over-range detector top: bus handshake, flag timing
   on channel a, disable and pin muxing.
   assumes it is bound into ordet_top and shadows ctrl and threshold. */
`timescale 1ns/1ps

module ordet_monitor
  import ordet_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ORDET_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CHAN-1:0][ORDET_SAMPLE_W-1:0] sample_data,
  input wire logic [NUM_CHAN-1:0] sample_valid,
  input wire logic flag_pin_chan_a,
  input wire logic flag_pin_chan_b,
  input wire logic flag_pin_chan_c,
  input wire logic flag_pin_chan_d,
  input wire logic chan_c_pin_refclk_function,
  input wire logic chan_d_pin_refclk_function
);
  logic en_ff;
  logic [ORDET_SEL_W-1:0] sel_ff;
  logic [7:0] thr_ff;
  logic [7:0] mag_a;
  logic [10:0] since_ff;
  logic [10:0] hold;
  logic [1:0] off_ff;
  logic hit_a;
  logic wr_ctl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // shadow state
  assign wr_ctl = psel && penable && pwrite && paddr == ORDET_CTRL_OFS;
  // shadow of the settings, taken on the same edge as the design
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_ff <= 1'b0;
      sel_ff <= ORDET_SEL_RST;
      thr_ff <= ORDET_THRESH_RST;
    end else if (wr_ctl) begin
      en_ff <= pwdata[ORDET_CTRL_EN_BIT];
      sel_ff <= pwdata[ORDET_CTRL_SEL_LSB +: ORDET_SEL_W];
    end else if (psel && penable && pwrite && paddr == ORDET_THRESH_OFS) begin
      thr_ff <= pwdata[7:0];
    end
  end
  // fold of channel a; -256 would wrap to 0, so it is pinned
  always_comb begin
    if (!sample_data[0][8]) mag_a = sample_data[0][7:0];
    else if (sample_data[0][7:0] == 8'h00) mag_a = ORDET_MAG_MAX;
    else mag_a = 8'h00 - sample_data[0][7:0];
  end
  assign hit_a = en_ff && sample_valid[0] && mag_a >= thr_ff;
  assign hold = ORDET_HOLD_BASE << sel_ff;
  // cycles since last hit; a ctrl write drops it so n may change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) since_ff <= 11'h000;
    else if (hit_a) since_ff <= 11'h001;
    else if (!en_ff || wr_ctl) since_ff <= 11'h000;
    else if (since_ff != 11'h000 && since_ff != 11'h7FF)
      since_ff <= since_ff + 11'h001;
  end
  // cycles with detection off, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) off_ff <= 2'h0;
    else if (en_ff) off_ff <= 2'h0;
    else if (off_ff != 2'h3) off_ff <= off_ff + 2'h1;
  end

  // ==========================================================
  // assertions
  AST_PREADY: assert property (psel |-> pready)
    else $error("pready low in a transfer");
  AST_SLVERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  AST_HIT_A: assert property (hit_a |-> ##2 flag_pin_chan_a)
    else $error("flag a missing after hit");
  AST_HOLD: assert property (
    en_ff && since_ff >= 11'h002 && since_ff <= hold + 11'h001
    |-> flag_pin_chan_a) else $error("flag a dropped early");
  AST_DROP: assert property (
    en_ff && since_ff == hold + 11'h002 |-> !flag_pin_chan_a)
    else $error("flag a held too long");
  AST_OFF: assert property (off_ff == 2'h3 |->
    !(flag_pin_chan_a || flag_pin_chan_b || flag_pin_chan_c ||
    flag_pin_chan_d)) else $error("flag while disabled");
  AST_REFC: assert property (
    chan_c_pin_refclk_function && $past(chan_c_pin_refclk_function)
    |-> !flag_pin_chan_c) else $error("flag c over clock");
  AST_REFD: assert property (
    chan_d_pin_refclk_function |-> chan_c_pin_refclk_function)
    else $error("pin d clock without pin c");
  cover property (hit_a);
  cover property (since_ff == hold + 11'h002);
  cover property (psel && penable && pslverr);
endmodule

bind ordet_top ordet_monitor #(.NUM_CHAN(NUM_CHAN)) i_ordet_monitor (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .sample_data, .sample_valid, .flag_pin_chan_a,
  .flag_pin_chan_b, .flag_pin_chan_c, .flag_pin_chan_d,
  .chan_c_pin_refclk_function, .chan_d_pin_refclk_function);

// [sim/ordet_top_tb_top.sv]
/* testbench for the over-range detector: apb master, sample driver,
   scenario tasks and verdict.
   assumes ordet_top with four channels and the gain model beside it. */
`timescale 1ns/1ps

module ordet_top_tb_top;
  import ordet_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0][8:0] sample_data;
  logic [3:0] sample_valid, pins;
  logic flag_pin_chan_a, flag_pin_chan_b, flag_pin_chan_c, flag_pin_chan_d;
  logic chan_c_pin_refclk_function, chan_d_pin_refclk_function;
  logic gain_low_ff;
  int err_count, cmp_count, cnt;
  assign pins = {flag_pin_chan_d, flag_pin_chan_c, flag_pin_chan_b,
    flag_pin_chan_a};

  // ==========================================================
  // design and partner
  ordet_top #(.NUM_CHAN(4)) i_ordet_top (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_data,
    .sample_valid, .flag_pin_chan_a, .flag_pin_chan_b, .flag_pin_chan_c,
    .flag_pin_chan_d, .chan_c_pin_refclk_function,
    .chan_d_pin_refclk_function, .irq);
  ordet_gain_model i_ordet_gain_model (.clk, .rst, .flags(pins),
    .gain_low_ff);
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits on pready, never on a fixed count
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task smp(input int ch, input logic [8:0] v);
    @(posedge clk);
    sample_data[ch] <= v;
    sample_valid[ch] <= 1'b1;
    @(posedge clk);
    sample_valid <= 4'h0;
  endtask
  // cycles that pin a stays up
  task hold_len;
    cnt = 0;
    repeat (1100) begin
      @(posedge clk);
      #1;
      if (flag_pin_chan_a === 1'b1) cnt++;
      else if (cnt > 0) break;
    end
  endtask
  task settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    apb(1'b0, ORDET_THRESH_OFS, 32'h0);
    chk_word(rd, 32'h0000_00E4);
    apb(1'b0, ORDET_CTRL_OFS, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk_word({rd[30:0], er}, 32'h1);
    chk_word(32'(pins), 32'h0);
    $display("test reset done");
  endtask
  task t_fold;
    logic [8:0] v[7] = '{9'h0FF, 9'h100, 9'h0FE, 9'h102, 9'h0FD,
      9'h103, 9'h000};
    apb(1'b1, ORDET_THRESH_OFS, 32'h0000_00FE);
    apb(1'b1, ORDET_CTRL_OFS, 32'h1);
    for (int i = 0; i < 7; i++) begin
      smp(i % 4, v[i]);
      settle(1);
      chk_word(32'(pins), (i < 4) ? 32'h1 << i : 32'h0);
      settle(12);
    end
    apb(1'b1, ORDET_THRESH_OFS, 32'h0000_00E4);
    $display("test fold done");
  endtask
  task t_hold;
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, ORDET_CTRL_OFS, 32'(1 + 2 * n));
      smp(0, 9'h100);
      hold_len;
      chk_word(32'(cnt), 32'(8 << n));
    end
    apb(1'b1, ORDET_CTRL_OFS, 32'h1);
    smp(0, 9'h100);
    repeat (5) @(posedge clk);
    smp(0, 9'h0FF);
    hold_len;
    chk_word(32'(cnt), 32'h8);
    $display("test hold done");
  endtask
  task t_off;
    apb(1'b1, ORDET_CTRL_OFS, 32'hF);
    smp(0, 9'h100);
    settle(1);
    chk_word(32'(pins), 32'h1);
    apb(1'b1, ORDET_CTRL_OFS, 32'h0);
    smp(0, 9'h100);
    smp(1, 9'h0FF);
    settle(3);
    chk_word(32'(pins), 32'h0);
    $display("test off done");
  endtask
  task t_ref;
    apb(1'b1, ORDET_CTRL_OFS, 32'h21);
    smp(3, 9'h100);
    settle(1);
    chk_word({chan_d_pin_refclk_function, pins}, 32'h8);
    settle(12);
    apb(1'b1, ORDET_CTRL_OFS, 32'h31);
    smp(2, 9'h100);
    smp(3, 9'h100);
    settle(1);
    chk_word({chan_d_pin_refclk_function, chan_c_pin_refclk_function,
      pins}, 32'h30);
    apb(1'b1, ORDET_CTRL_OFS, 32'h1);
    settle(12);
    $display("test ref done");
  endtask
  task t_irq;
    apb(1'b1, ORDET_IRQ_STAT_OFS, 32'hF);
    apb(1'b1, ORDET_IRQ_MASK_OFS, 32'h1);
    smp(1, 9'h100);
    settle(2);
    chk_word(32'(irq), 32'h0);
    apb(1'b0, ORDET_IRQ_STAT_OFS, 32'h0);
    chk_word(rd, 32'h2);
    smp(0, 9'h100);
    settle(2);
    chk_word({irq, gain_low_ff}, 32'h3);
    apb(1'b1, ORDET_IRQ_STAT_OFS, 32'h1);
    settle(1);
    chk_word(32'(irq), 32'h0);
    settle(12);
    chk_word(32'(gain_low_ff), 32'h0);
    $display("test irq done");
  endtask
  // flags word, peak capture and clear, mask readback
  task t_regs;
    smp(0, 9'h100);
    apb(1'b0, ORDET_FLAGS_OFS, 32'h0);
    chk_word(rd, 32'h1);
    apb(1'b0, ORDET_PEAK_BASE_OFS, 32'h0);
    chk_word(rd, 32'hFF);
    smp(0, 9'h010);
    apb(1'b1, ORDET_PEAK_BASE_OFS, 32'h0);
    apb(1'b0, ORDET_PEAK_BASE_OFS, 32'h0);
    chk_word(rd, 32'h10);
    apb(1'b0, ORDET_IRQ_MASK_OFS, 32'h0);
    chk_word(rd, 32'h1);
    $display("test regs done");
  endtask
  // reset in mid-run while a long flag stands
  task t_rst2;
    apb(1'b1, ORDET_CTRL_OFS, 32'hF);
    apb(1'b1, ORDET_THRESH_OFS, 32'h10);
    smp(0, 9'h100);
    settle(1);
    chk_word(32'(pins), 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk_word(32'(pins), 32'h0);
    apb(1'b0, ORDET_THRESH_OFS, 32'h0);
    chk_word(rd, 32'h0000_00E4);
    apb(1'b0, ORDET_CTRL_OFS, 32'h0);
    chk_word(rd, 32'h0);
    $display("test rst2 done");
  endtask

  // ==========================================================
  // verdict, main sequence and watchdog
  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_data = '0;
    sample_valid = 4'h0;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_fold;
    t_hold;
    t_off;
    t_ref;
    t_irq;
    t_regs;
    t_rst2;
    wrap_up;
  end
  // tests need about 2400 cycles; a hang is cut at 20000
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up;
  end
endmodule
